// [core/fpsc_cmd.sv]
`timescale 1ns/100ps
module fpsc_cmd
  import fpsc_pkg::*;
#(
  parameter logic [7:0] LEGACY_ID_BYTE = 8'h5a, // arbitrary value
  parameter logic [7:0] STD_ID_DEVICE  = 8'ha1, // arbitrary value
  parameter logic [7:0] STD_ID_TYPE    = 8'hb2, // arbitrary value
  parameter logic [7:0] STD_ID_SIZE    = 8'hc3, // arbitrary value
  parameter logic [7:0] STD_ID_RSVD    = 8'hd4  // arbitrary value
) (
  input  wire logic sys_clk_in,                  // block clock, 100 MHz
  input  wire logic srst_in,                     // sync reset, high
  input  wire logic cs_n_in,                     // chip select pin, low
  input  wire logic sck_in,                      // serial clock pin
  input  wire logic mosi_in,                     // serial data in pin
  input  wire logic wp_n_in,                     // write-protect pin, low
  input  wire logic prog_busy_in,                // program/erase running
  output logic      miso_out,                    // serial data out
  output logic      miso_oe_out,                 // serial data out enable
  output logic      protect_range_bit_low_out,   // range bit 0
  output logic      protect_range_bit_high_out,  // range bit 1
  output logic      protect_from_bottom_select_out, // range from bottom
  output logic      protect_lockdown_bit_out,    // lock-down bit
  output logic      write_latch_out,             // write enable latch
  output logic      status_write_busy_out,       // self-timed write running
  output logic      deep_sleep_mode_out,         // deep sleep active
  output logic      low_power_out                // lowest power reached
);
  import fpsc_pkg::*;

  // frame phase
  typedef enum logic [2:0] {
    PH_IDLE,       // chip select high
    PH_OPCODE,     // collecting opcode bits
    PH_HOLD,       // opcode-only command, acts at frame end
    PH_DUMMY,      // legacy id dummy bits
    PH_DATA,       // status write data
    PH_OUT_LEGACY, // repeating legacy id
    PH_OUT_STD,    // repeating four-byte id
    PH_OUT_STATUS  // repeating status byte
  } fpsc_phase_t;

  // what the running timer stands for
  typedef enum logic [1:0] {
    TM_NONE,  // idle
    TM_WRITE, // status write cycle
    TM_ENTRY, // sleep entry settling
    TM_EXIT   // sleep exit recovery
  } fpsc_tmode_t;

  typedef struct packed {
    logic        sck_prev;  // last sampled serial clock
    logic        cs_prev;   // last sampled chip select
    fpsc_phase_t ph;        // frame phase
    logic        skip;      // frame discarded
    logic [5:0]  nbits;     // rising edges in frame, saturating
    logic [7:0]  sh_in;     // input shifter
    logic [7:0]  opc;       // opcode of the frame
    logic [7:0]  wdata;     // status write data byte
    logic [7:0]  sh_out;    // output shifter
    logic [2:0]  out_cnt;   // bits sent of current byte
    logic [1:0]  id_idx;    // standard id byte index
    logic        miso;      // output data flop
    logic        miso_oe;   // output enable flop
    logic        bp0;       // protect_range_bit_low
    logic        bp1;       // protect_range_bit_high
    logic        tb;        // protect_from_bottom_select
    logic        protect_lockdown_bit;       // protect_lockdown_bit
    logic        wel;       // write enable latch
    logic        wr_busy;   // status write cycle running
    logic        sleep;     // deep_sleep_mode
    logic        exit_pend; // waiting out the exit delay
    logic        low_pwr;   // entry delay has passed
    fpsc_tmode_t tmode;     // timer owner
  } fpsc_state_t;

  fpsc_state_t      q;         // registered state
  fpsc_state_t      d;         // next state
  logic [3:0]       pins_s;    // synchronised pins
  logic             s_cs_n;    // synced chip select
  logic             s_sck;     // synced serial clock
  logic             s_mosi;    // synced data in
  logic             s_wp_n;    // synced write protect
  logic             tmr_done;  // timer expiry pulse
  logic             tmr_load;  // timer start
  logic [TMR_W-1:0] tmr_val;   // timer length
  logic             cs_rise;   // frame end
  logic             wr_go;     // status write accepted
  logic             sleep_go;  // sleep entry accepted
  logic [7:0]       stat;      // status byte as read
  logic [7:0]       in_byte;   // byte completed this edge
  logic             sck_rise;  // serial clock rising
  logic             sck_fall;  // serial clock falling
  logic             cs_fall;   // frame start
  logic             wp_low;    // hardware protect asserted
  logic             busy_any;  // any internal write running

  // pins cross in as levels; edges are found on the retimed copies
  fpsc_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .async_in   ({cs_n_in, sck_in, mosi_in, wp_n_in}),
    .sync_out   (pins_s)
  );
  assign {s_cs_n, s_sck, s_mosi, s_wp_n} = pins_s;

  // one timer serves all three delays; they never overlap legally
  fpsc_timer u_timer (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .load_in    (tmr_load),
    .count_in   (tmr_val),
    .done_out   (tmr_done)
  );

  // standard id byte by position
  function automatic logic [7:0] std_byte(input logic [1:0] idx);
    logic [7:0] b;
    unique case (idx)
      2'h0: b = STD_ID_DEVICE;
      2'h1: b = STD_ID_TYPE;
      2'h2: b = STD_ID_SIZE;
      2'h3: b = STD_ID_RSVD;
    endcase
    return b;
  endfunction : std_byte

  // next-state logic: pin edges, frame decode, frame-end actions
  always_comb begin
    d        = q;
    tmr_load = 1'b0;
    tmr_val  = '0;
    wr_go    = 1'b0;
    sleep_go = 1'b0;
    sck_rise = s_sck & ~q.sck_prev;
    sck_fall = ~s_sck & q.sck_prev;
    cs_fall  = ~s_cs_n & q.cs_prev;
    cs_rise  = s_cs_n & ~q.cs_prev;
    wp_low   = ~s_wp_n;
    busy_any = q.wr_busy | prog_busy_in;
    in_byte  = {q.sh_in[6:0], s_mosi};
    d.sck_prev = s_sck;
    d.cs_prev  = s_cs_n;
    // status byte, rebuilt live so polling sees busy fall
    stat = '0;
    stat[SR_BUSY_POS]       = busy_any;
    stat[SR_WEL_POS]        = q.wel;
    stat[SR_RANGE_LOW_POS]  = q.bp0;
    stat[SR_RANGE_HIGH_POS] = q.bp1;
    stat[SR_BOTTOM_POS]     = q.tb;
    stat[SR_LOCKDOWN_POS]   = q.protect_lockdown_bit;
    // delay expiry
    if (tmr_done) begin
      d.tmode = TM_NONE;
      unique case (q.tmode)
        TM_WRITE: d.wr_busy = 1'b0;
        TM_ENTRY: d.low_pwr = 1'b1;
        TM_EXIT: begin
          d.sleep     = 1'b0;
          d.exit_pend = 1'b0;
        end
        TM_NONE: ;
      endcase
    end
    if (cs_fall) begin
      // new frame
      d.ph      = PH_OPCODE;
      d.skip    = 1'b0;
      d.nbits   = '0;
      d.out_cnt = '0;
      d.id_idx  = '0;
    end else if (cs_rise) begin
      // frame end: output released at once, even mid-byte
      d.ph      = PH_IDLE;
      d.miso    = 1'b0;
      d.miso_oe = 1'b0;
      if (!q.skip && q.ph != PH_OPCODE && q.ph != PH_IDLE) begin
        if (q.opc == OPC_STATUS_WRITE) begin
          // exactly one data byte, no write running, lock not engaged
          if (q.nbits == BITS_STATUS_WRITE && !busy_any
              && !(wp_low && q.protect_lockdown_bit)) begin
            wr_go     = 1'b1;
            d.bp0     = q.wdata[SR_RANGE_LOW_POS];
            d.bp1     = q.wdata[SR_RANGE_HIGH_POS];
            d.tb      = q.wdata[SR_BOTTOM_POS];
            // with protect low only a set can reach the lock bit
            d.protect_lockdown_bit     = wp_low ? (q.protect_lockdown_bit | q.wdata[SR_LOCKDOWN_POS])
                               : q.wdata[SR_LOCKDOWN_POS];
            d.wel     = 1'b0;
            d.wr_busy = 1'b1;
            d.tmode   = TM_WRITE;
            tmr_load  = 1'b1;
            tmr_val   = CYC_STATUS_WRITE;
          end
        end else if (q.opc == OPC_WRITE_LATCH_SET) begin
          if (q.nbits == BITS_OPCODE) begin
            d.wel = 1'b1;
          end
        end else if (q.opc == OPC_WRITE_LATCH_CLR) begin
          if (q.nbits == BITS_OPCODE) begin
            d.wel = 1'b0;
          end
        end else if (q.opc == OPC_SLEEP_ENTER) begin
          if (q.nbits == BITS_OPCODE && !busy_any) begin
            sleep_go  = 1'b1;
            d.sleep   = 1'b1;
            d.low_pwr = 1'b0;
            d.tmode   = TM_ENTRY;
            tmr_load  = 1'b1;
            tmr_val   = CYC_SLEEP_ENTRY;
          end
        end else if (q.opc == OPC_LEGACY_ID && q.sleep) begin
          // release or legacy id both wake the part
          d.exit_pend = 1'b1;
          d.low_pwr   = 1'b0;
          d.tmode     = TM_EXIT;
          tmr_load    = 1'b1;
          tmr_val     = CYC_SLEEP_EXIT;
        end
      end
    end else if (!s_cs_n) begin
      if (sck_rise) begin
        // shift in on the rising edge
        d.sh_in = in_byte;
        if (q.nbits != BITS_SAT) begin
          d.nbits = q.nbits + 6'h01;
        end
        unique case (q.ph)
          PH_OPCODE: begin
            if (q.nbits == BITS_LAST_OPCODE) begin
              d.opc = in_byte;
              // asleep: discard all but the wake opcode; recovering (exit_pend): discard all
              if (q.sleep && (q.exit_pend || in_byte != OPC_LEGACY_ID)) begin
                d.skip = 1'b1;
                d.ph   = PH_HOLD;
              end else if (in_byte == OPC_STD_ID) begin
                d.ph     = PH_OUT_STD;
                d.sh_out = std_byte(2'h0);
              end else if (in_byte == OPC_STATUS_READ) begin
                d.ph     = PH_OUT_STATUS;
                d.sh_out = stat;
              end else if (in_byte == OPC_LEGACY_ID) begin
                d.ph = PH_DUMMY;
              end else if (in_byte == OPC_STATUS_WRITE) begin
                d.ph = PH_DATA;
              end else begin
                d.ph = PH_HOLD;
              end
            end
          end
          PH_DUMMY: begin
            if (q.nbits == BITS_LAST_DUMMY) begin
              d.ph     = PH_OUT_LEGACY;
              d.sh_out = LEGACY_ID_BYTE;
            end
          end
          PH_DATA: begin
            if (q.nbits == BITS_LAST_DATA) begin
              d.wdata = in_byte;
            end
          end
          PH_IDLE, PH_HOLD, PH_OUT_LEGACY, PH_OUT_STD, PH_OUT_STATUS: ;
        endcase
      end
      if (sck_fall && (q.ph == PH_OUT_LEGACY || q.ph == PH_OUT_STD
                       || q.ph == PH_OUT_STATUS)) begin
        // shift out on the falling edge, msb first
        d.miso    = q.sh_out[7];
        d.miso_oe = 1'b1;
        d.sh_out  = {q.sh_out[6:0], 1'b0};
        d.out_cnt = q.out_cnt + 3'h1;
        if (q.out_cnt == 3'h7) begin
          if (q.ph == PH_OUT_LEGACY) begin
            d.sh_out = LEGACY_ID_BYTE;
          end else if (q.ph == PH_OUT_STD) begin
            d.id_idx = q.id_idx + 2'h1;
            d.sh_out = std_byte(q.id_idx + 2'h1);
          end else begin
            d.sh_out = stat;
          end
        end
      end
    end
  end

  // state register; reset leaves protection on and the part awake
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      q         <= '0;
      q.ph      <= PH_IDLE;
      q.cs_prev <= 1'b1;
      q.bp0     <= RST_RANGE_LOW;
      q.bp1     <= RST_RANGE_HIGH;
      q.tb      <= RST_BOTTOM;
      q.protect_lockdown_bit     <= RST_LOCKDOWN;
      q.wel     <= RST_WEL;
      q.tmode   <= TM_NONE;
    end else begin
      q <= d;
    end
  end

  assign miso_out                       = q.miso;
  assign miso_oe_out                    = q.miso_oe;
  assign protect_range_bit_low_out      = q.bp0;
  assign protect_range_bit_high_out     = q.bp1;
  assign protect_from_bottom_select_out = q.tb;
  assign protect_lockdown_bit_out       = q.protect_lockdown_bit;
  assign write_latch_out                = q.wel;
  assign status_write_busy_out          = q.wr_busy;
  assign deep_sleep_mode_out            = q.sleep;
  assign low_power_out                  = q.low_pwr;

  // checks on the design's own behaviour
  localparam int WR_DONE_CYC = int'(CYC_STATUS_WRITE) + 1;  // busy length
  localparam int SLP_DONE_CYC = int'(CYC_SLEEP_ENTRY) + 1;  // entry length

  a_release_on_end: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    cs_rise |=> !miso_oe_out ##1 !miso_oe_out)
    else $error("data out still driven after frame end");

  a_locked_no_write: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    cs_rise && wp_low && q.protect_lockdown_bit |=> $stable({q.bp0, q.bp1, q.tb, q.protect_lockdown_bit}))
    else $error("locked status register changed");

  a_lockdown_sticky: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    wp_low && q.protect_lockdown_bit |=> protect_lockdown_bit_out)
    else $error("lock-down cleared while protect pin low");

  a_write_busy_len: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    wr_go |=> status_write_busy_out ##[WR_DONE_CYC:WR_DONE_CYC] !status_write_busy_out)
    else $error("status write cycle length wrong");

  a_wel_cleared: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    wr_go |=> !write_latch_out)
    else $error("write latch not cleared by status write");

  a_sleep_busy_ign: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    cs_rise && q.opc == OPC_SLEEP_ENTER && busy_any && !q.sleep
    |=> !deep_sleep_mode_out)
    else $error("sleep entered while a write was running");

  a_sleep_low_power: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    sleep_go |=> deep_sleep_mode_out && !low_power_out
    ##[SLP_DONE_CYC:SLP_DONE_CYC] low_power_out)
    else $error("sleep entry delay wrong");

  a_sleep_discard: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    cs_rise && q.sleep && q.opc != OPC_LEGACY_ID
    |=> $stable({q.wel, q.bp0, q.bp1, q.tb, q.protect_lockdown_bit}))
    else $error("command acted on during deep sleep");

  a_extra_data_rej: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    cs_rise && q.opc == OPC_STATUS_WRITE && q.nbits > BITS_STATUS_WRITE |-> !wr_go)
    else $error("status write with extra data accepted");

  a_std_id_drive: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    sck_fall && !s_cs_n && q.ph == PH_OUT_STD && !q.sh_out[7] |=> miso_oe_out && !miso_out)
    else $error("standard id bit not driven");

endmodule : fpsc_cmd

// [include/fpsc_pkg.sv]
package fpsc_pkg;

  // clock of the block
  localparam int CLK_PERIOD_NS = 10;               // sys_clk_in period

  // command opcodes
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01; // status_write_command
  localparam logic [7:0] OPC_WRITE_LATCH_CLR = 8'h04; // write latch clear
  localparam logic [7:0] OPC_STATUS_READ = 8'h05;  // status_read_command
  localparam logic [7:0] OPC_WRITE_LATCH_SET = 8'h06; // write_latch_set_command
  localparam logic [7:0] OPC_STD_ID = 8'h9f;       // four-byte standard id read
  localparam logic [7:0] OPC_LEGACY_ID = 8'hab;    // legacy id read / sleep release
  localparam logic [7:0] OPC_SLEEP_ENTER = 8'hb9;  // deep_sleep_mode entry

  // frame lengths in serial clocks
  localparam logic [5:0] BITS_OPCODE = 6'h08;      // opcode only
  localparam logic [5:0] BITS_STATUS_WRITE = 6'h10; // opcode plus one data byte
  localparam logic [5:0] BITS_LAST_OPCODE = 6'h07; // index of last opcode bit
  localparam logic [5:0] BITS_LAST_DATA = 6'h0f;   // index of last data bit
  localparam logic [5:0] BITS_LAST_DUMMY = 6'h1f;  // index of last dummy bit
  localparam logic [5:0] BITS_SAT = 6'h3f;         // frame bit counter ceiling

  // status byte bit positions
  localparam int SR_BUSY_POS = 0;                  // self-timed write running
  localparam int SR_WEL_POS = 1;                   // write enable latch
  localparam int SR_RANGE_LOW_POS = 2;             // protect_range_bit_low
  localparam int SR_RANGE_HIGH_POS = 3;            // protect_range_bit_high
  localparam int SR_BOTTOM_POS = 5;                // protect_from_bottom_select
  localparam int SR_LOCKDOWN_POS = 7;              // protect_lockdown_bit

  // values after reset
  localparam logic RST_RANGE_LOW = 1'b1;           // protection on after reset
  localparam logic RST_RANGE_HIGH = 1'b1;          // protection on after reset
  localparam logic RST_BOTTOM = 1'b0;              // top protected
  localparam logic RST_LOCKDOWN = 1'b0;            // lock-down off
  localparam logic RST_WEL = 1'b0;                 // write latch clear; status writes are not gated by it

  // self-timed delays, figures in ns
  localparam int TIME_STATUS_WRITE_NS = 5000;      // status_write_time
  localparam int TIME_SLEEP_ENTRY_NS = 3000;       // sleep_entry_delay
  localparam int TIME_SLEEP_EXIT_NS = 3000;        // sleep_exit_delay

  // delays in clock cycles, rounded up
  localparam int TMR_W = 16;                       // timer width
  localparam logic [15:0] CYC_STATUS_WRITE =
    16'((TIME_STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] CYC_SLEEP_ENTRY =
    16'((TIME_SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] CYC_SLEEP_EXIT =
    16'((TIME_SLEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // pins that pass the synchroniser
  localparam int SYNC_W = 4;                       // cs, sck, mosi, wp
  localparam logic [3:0] SYNC_RST = 4'h9;          // cs and wp idle high

endpackage : fpsc_pkg

// [core/fpsc_sync.sv]
`timescale 1ns/100ps
// two-stage synchroniser for the serial pins
module fpsc_sync
  import fpsc_pkg::*;
(
  input  wire logic                        sys_clk_in, // block clock
  input  wire logic                        srst_in,    // sync reset, high
  input  wire logic [fpsc_pkg::SYNC_W-1:0] async_in,   // raw pin levels
  output logic      [fpsc_pkg::SYNC_W-1:0] sync_out    // retimed levels
);
  import fpsc_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] meta; // first stage, read only by the second
    logic [SYNC_W-1:0] safe; // second stage
  } fpsc_sync_t;

  fpsc_sync_t q; // registered state
  fpsc_sync_t d; // next state

  // shift the pins through both stages
  always_comb begin
    d      = q;
    d.meta = async_in;
    d.safe = q.meta;
  end

  // reset to idle pin levels so no false frame edge follows reset
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      q <= {SYNC_RST, SYNC_RST};
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.safe;

endmodule : fpsc_sync

// [core/fpsc_timer.sv]
`timescale 1ns/100ps
// one-shot down counter for the self-timed delays
module fpsc_timer
  import fpsc_pkg::*;
(
  input  wire logic                       sys_clk_in, // block clock
  input  wire logic                       srst_in,    // sync reset, high
  input  wire logic                       load_in,    // start, pulse
  input  wire logic [fpsc_pkg::TMR_W-1:0] count_in,   // cycles to run
  output logic                            done_out    // expiry, pulse
);
  import fpsc_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;  // cycles left
    logic             done; // expiry pulse
  } fpsc_tmr_t;

  fpsc_tmr_t q; // registered state
  fpsc_tmr_t d; // next state

  // a new load restarts the count, so a later request overrides
  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (load_in) begin
      d.cnt = count_in;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 16'h0001;
      d.done = (q.cnt == 16'h0001);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_out = q.done;

endmodule : fpsc_timer

// [verification/fpsc_host.sv]
`timescale 1ns/100ps
// host side: spi mode 0 master, sck idle low, 80 ns serial period
module fpsc_host (
  input  wire logic sys_clk_in, // bench clock
  input  wire logic miso_in,    // device data
  input  wire logic miso_oe_in, // device drives data
  output logic      cs_n_out,   // chip select, low
  output logic      sck_out,    // serial clock
  output logic      mosi_out    // serial data
);
  logic last_q; // level seen last cycle
  logic line;   // released line flips so stale data never passes
  assign line = miso_oe_in ? miso_in : ~last_q;
  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    mosi_out = 1'b0;
    last_q   = 1'b0;
  end
  always @(posedge sys_clk_in) last_q <= line;
  // wait whole clocks, changes land just after a falling edge
  task automatic gap(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : gap
  // n bits out msb first, last c bits taken back on sck rises
  task automatic frame(input logic [63:0] tx, input int n, input int c,
                       output logic [63:0] rx);
    rx = '0;
    gap(1);
    cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi_out = tx[i];
      gap(4);
      sck_out = 1'b1;
      if (i < c) rx = {rx[62:0], line};
      gap(4);
      sck_out = 1'b0;
    end
    gap(4);
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    gap(8);
  endtask : frame
endmodule : fpsc_host

// [verification/flash_protect_sleep_id_cmds_test.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module flash_protect_sleep_id_cmds_test;
  import fpsc_pkg::*;
  logic clk, srst, wp_n, pbusy, cs_n, sck, mosi, miso, oe; // pins
  logic rlo, rhi, bot, lock, latch, busy, sleep, lowp;      // status outputs
  logic [63:0] exp_q[$]; // expected results, oldest first
  logic [63:0] got;      // latest result
  logic [63:0] exp_v;    // oldest note, taken off the queue once
  event        got_ev;   // a result appeared
  logic [31:0] rng = 32'h1f; // xorshift state
  logic [7:0]  d;        // random status data
  int miscompares = 0;
  int n_checks = 0;
  fpsc_cmd DUT (.sys_clk_in(clk), .srst_in(srst), .cs_n_in(cs_n), .sck_in(sck),
    .mosi_in(mosi), .wp_n_in(wp_n), .prog_busy_in(pbusy), .miso_out(miso),
    .miso_oe_out(oe), .protect_range_bit_low_out(rlo), .protect_range_bit_high_out(rhi),
    .protect_from_bottom_select_out(bot), .protect_lockdown_bit_out(lock),
    .write_latch_out(latch), .status_write_busy_out(busy),
    .deep_sleep_mode_out(sleep), .low_power_out(lowp));
  fpsc_host HOST (.sys_clk_in(clk), .miso_in(miso), .miso_oe_in(oe),
    .cs_n_out(cs_n), .sck_out(sck), .mosi_out(mosi));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  // port snapshot laid out like the status byte, plus oe, sleep, low power
  function automatic logic [63:0] st();
    return {53'h0, oe, sleep, lowp, lock, 1'b0, bot, 1'b0, rhi, rlo, latch, busy};
  endfunction : st
  task automatic post(input logic [63:0] e, input logic [63:0] g);
    exp_q.push_back(e);
    got = g;
    ->got_ev;
    #1;
  endtask : post
  // read frame: compare the returned bits
  task automatic rd(input logic [63:0] tx, input int n, input int c, input logic [63:0] e);
    logic [63:0] r;
    HOST.frame(tx, n, c, r);
    post(e, r);
  endtask : rd
  // any other frame: compare the ports, then let a self-timed write finish
  task automatic wr(input logic [63:0] tx, input int n, input logic [63:0] e);
    logic [63:0] r;
    HOST.frame(tx, n, 0, r);
    post(e, st());
    HOST.gap(520);
  endtask : wr
  // checker: oldest note against each result as it appears
  always @(got_ev) begin
    exp_v = exp_q.pop_front();
    `CHK(got, exp_v)
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // the whole sequence takes about 120 us; a hang is caught at about three and a third times that
  initial begin
    #400000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    srst = 1'b1;
    wp_n = 1'b1;
    pbusy = 1'b0;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    rd(64'h0500, 16, 8, 64'h0c);
    rd({8'h9f, 40'h0}, 48, 40, 64'ha1b2c3d4a1);
    rd({8'hab, 40'h0}, 48, 16, 64'h5a5a);
    rd({8'h9f, 12'h0}, 20, 12, 64'ha1b);
    post(64'h0c, st());
    wr(64'h06, 8, 64'h0e);
    wr(64'h01ff, 16, 64'h0ad);
    @(negedge clk) wp_n = 1'b0;
    wr(64'h0100, 16, 64'h0ac);
    @(negedge clk) wp_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      d = 8'(xs());
      wr({8'h01, d}, 16, {56'h0, d & 8'hac} | 64'h1);
    end
    wr(64'h0100, 16, 64'h01);
    @(negedge clk) wp_n = 1'b0;
    wr(64'h018c, 16, 64'h08d);
    @(negedge clk) wp_n = 1'b1;
    wr(64'h0100, 16, 64'h01);
    wr(64'h00ff, 15, 64'h00);
    wr(64'h01ffff, 24, 64'h00);
    // the busy port shows only the status write, not the program engine
    @(negedge clk) pbusy = 1'b1;
    wr(64'hb9, 8, 64'h00);
    @(negedge clk) pbusy = 1'b0;
    wr(64'hb9, 8, 64'h200);
    wr(64'h06, 8, 64'h300);
    wr(64'hab, 8, 64'h200);
    wr(64'h06, 8, 64'h02);
    wr(64'h04, 8, 64'h00);
    tally_and_finish();
  end
endmodule : flash_protect_sleep_id_cmds_test
